/* File: rtl/mmd_decoder.sv */
// Top of the memory map decoder: bank select, data routing, dual pointers
`default_nettype none
module mmd_decoder (
  input wire logic ref_clk,
  input wire logic reset,
  input wire mmd_pkg::mmd_rst_e resetCause,
  input wire logic startupCfgLow,
  input wire logic startupCfgHigh,
  input wire logic bankLowWrEn,
  input wire logic bankLowWrData,
  input wire logic fetchValid,
  input wire logic [15:0] pc,
  input wire mmd_pkg::mmd_dreq_s dataReq,
  input wire logic auxWrEn,
  input wire logic [7:0] auxWrData,
  input wire logic auxInc,
  input wire logic ptrWrEn,
  input wire logic [15:0] ptrWrData,
  input wire logic ptrInc,
  input wire logic externalOnlyFlag,
  output logic [1:0] bankSel,
  output mmd_pkg::mmd_fetch_e fetchTarget,
  output logic [15:0] fetchOffset,
  output mmd_pkg::mmd_data_e dataTarget,
  output logic [9:0] eramAddr,
  output mmd_pkg::mmd_bus_s busOut,
  output logic pointerSelectBit,
  output logic [15:0] dataPointer
);
  logic [1:0] bank_q, bank_d;
  logic [7:0] aux_q, aux_d;
  logic [15:0] ptr_q [2];
  logic [15:0] ptr_d [2];
  mmd_pkg::mmd_fetch_e fetch_q, fetch_d, mapTarget;
  logic [15:0] fofs_q, fofs_d, mapOffset;
  mmd_pkg::mmd_data_e dtgt_q, dtgt_d;
  logic [9:0] expanded_ram_q, expanded_ram_d;
  mmd_pkg::mmd_bus_s bus_q, bus_d;
  logic [15:0] data_pointer_q, data_pointer_d;

  // Bank field: reset cause picks the load; an unlisted cause loads BankPorReset
  always_comb begin
    bank_d = bank_q;
    if (reset) begin
      unique case (resetCause)
        mmd_pkg::RstPor: bank_d = {~startupCfgHigh, ~startupCfgLow};
        mmd_pkg::RstWdt, mmd_pkg::RstBod:
          bank_d = {bank_q[1] | ~startupCfgHigh, ~startupCfgLow};
        mmd_pkg::RstSoft: bank_d = {1'b1, ~startupCfgLow};
        default: bank_d = mmd_pkg::BankPorReset;
      endcase
    end else if (bankLowWrEn) begin
      bank_d[mmd_pkg::BankLoPos] = bankLowWrData;
    end
  end

  // The reset-time load is a clocked capture of the straps, never an async load
  always_ff @(posedge ref_clk) begin
    bank_q <= bank_d;
  end

  // Bank writes already seen by the mapper on the next cycle's fetch
  mmd_fetch_map uMap (
    .bank(bank_q),
    .pc(pc),
    .target(mapTarget),
    .offset(mapOffset)
  );

  always_comb begin
    fetch_d = fetchValid ? mapTarget : mmd_pkg::FetchNone;
    fofs_d = mapOffset;
    if (reset) fetch_d = mmd_pkg::FetchNone;
  end

  always_ff @(posedge ref_clk) begin
    fetch_q <= fetch_d;
    fofs_q <= fofs_d;
  end

  // Auxiliary register and pointer bank
  always_comb begin
    aux_d = aux_q;
    ptr_d = ptr_q;
    if (auxWrEn) aux_d = auxWrData;
    else if (auxInc) aux_d = aux_q + 8'h01;
    if (ptrWrEn) ptr_d[aux_q[mmd_pkg::SelBitPos]] = ptrWrData;
    else if (ptrInc) ptr_d[aux_q[mmd_pkg::SelBitPos]] =
      ptr_q[aux_q[mmd_pkg::SelBitPos]] + 16'h0001;
    if (reset) begin
      aux_d = 8'h00;
      ptr_d[0] = 16'h0000;
      ptr_d[1] = 16'h0000;
    end
    // Selected pointer is registered so the output leaves a flop, not a mux
    data_pointer_d = ptr_d[aux_d[mmd_pkg::SelBitPos]];
  end

  always_ff @(posedge ref_clk) begin
    aux_q <= aux_d;
    ptr_q <= ptr_d;
    data_pointer_q <= data_pointer_d;
  end

  // Data routing: internal space, expanded RAM or external bus
  always_comb begin
    dtgt_d = mmd_pkg::DataNone;
    expanded_ram_d = expanded_ram_q;
    bus_d = '0;
    if (dataReq.valid && !reset) begin
      if (!dataReq.ext) begin
        // Stack traffic arrives here as indirect, so it never leaves 256 bytes
        if (dataReq.addr[7:0] <= mmd_pkg::LowRamTop) dtgt_d = mmd_pkg::DataLowRam;
        else if (dataReq.indirect) dtgt_d = mmd_pkg::DataUpperRam;
        else dtgt_d = mmd_pkg::DataSfr;
      end else if (!externalOnlyFlag && dataReq.viaPtr && dataReq.addr <= mmd_pkg::EramTop) begin
        dtgt_d = mmd_pkg::DataEram;
        expanded_ram_d = dataReq.addr[9:0];
      end else if (!externalOnlyFlag && !dataReq.viaPtr) begin
        dtgt_d = mmd_pkg::DataEram;
        expanded_ram_d = {2'h0, dataReq.addr[7:0]};
      end else begin
        dtgt_d = mmd_pkg::DataExtBus;
        bus_d.rdStrobe = !dataReq.write;
        bus_d.wrStrobe = dataReq.write;
        bus_d.port0En = 1'b1;
        bus_d.port0 = dataReq.addr[7:0];
        bus_d.port2En = dataReq.viaPtr;
        bus_d.port2 = dataReq.viaPtr ? dataReq.addr[15:8] : 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    dtgt_q <= dtgt_d;
    expanded_ram_q <= reset ? 10'h000 : expanded_ram_d;
    bus_q <= bus_d;
  end

  assign bankSel = bank_q;
  assign fetchTarget = fetch_q;
  assign fetchOffset = fofs_q;
  assign dataTarget = dtgt_q;
  assign eramAddr = expanded_ram_q;
  assign busOut = bus_q;
  assign pointerSelectBit = aux_q[mmd_pkg::SelBitPos];
  assign dataPointer = data_pointer_q;

  // Checks
  property p_por_load;
    @(posedge ref_clk) reset && resetCause == mmd_pkg::RstPor |=>
      bankSel == {~$past(startupCfgHigh), ~$past(startupCfgLow)};
  endproperty
  a_por_load: assert property (p_por_load) else $error("power-on bank load wrong");

  property p_soft_load;
    @(posedge ref_clk) reset && resetCause == mmd_pkg::RstSoft |=>
      bankSel[1] && bankSel[0] == ~$past(startupCfgLow);
  endproperty
  a_soft_load: assert property (p_soft_load) else $error("software reset bank load wrong");

  property p_wdt_load;
    @(posedge ref_clk) reset && resetCause == mmd_pkg::RstWdt |=>
      bankSel[1] == ($past(bankSel[1]) | ~$past(startupCfgHigh));
  endproperty
  a_wdt_load: assert property (p_wdt_load) else $error("watchdog bank load wrong");

  property p_low_write;
    @(posedge ref_clk) disable iff (reset) bankLowWrEn |=> bankSel[0] == $past(bankLowWrData);
  endproperty
  a_low_write: assert property (p_low_write) else $error("bank low write lost");

  property p_hidden;
    @(posedge ref_clk) disable iff (reset) fetchTarget != mmd_pkg::FetchSecondary ||
      !$past(bankSel[1]);
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden block fetched");

  property p_overlay;
    @(posedge ref_clk) disable iff (reset) fetchValid && bankSel == 2'h0 && pc <= 16'h1fff
      |=> fetchTarget == mmd_pkg::FetchSecondary;
  endproperty
  a_overlay: assert property (p_overlay) else $error("overlay fetch wrong");

  property p_ptr_toggle;
    @(posedge ref_clk) disable iff (reset) auxInc && !auxWrEn |=>
      pointerSelectBit != $past(pointerSelectBit);
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer select not toggled");

  property p_no_strobe;
    @(posedge ref_clk) disable iff (reset) dataTarget == mmd_pkg::DataEram |->
      !busOut.rdStrobe && !busOut.wrStrobe && !busOut.port0En && !busOut.port2En;
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("strobe on expanded RAM");

  property p_ext_strobe;
    @(posedge ref_clk) disable iff (reset) dataReq.valid && dataReq.ext && externalOnlyFlag
      |=> busOut.rdStrobe || busOut.wrStrobe;
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("external move without strobe");

  // Brown-out shares the watchdog load; both bits are checked here
  property p_bod_load;
    @(posedge ref_clk) reset && resetCause == mmd_pkg::RstBod |=>
      bankSel[1] == ($past(bankSel[1]) | ~$past(startupCfgHigh)) &&
      bankSel[0] == ~$past(startupCfgLow);
  endproperty
  a_bod_load: assert property (p_bod_load) else $error("brown-out bank load wrong");

  // Without a write the bank field must not drift between resets
  property p_bank_hold;
    @(posedge ref_clk) disable iff (reset) !bankLowWrEn |=> $stable(bankSel);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank field drifted");

  // Fetch mapping checks; each follows one request by one edge
  property p_dual_fetch;
    @(posedge ref_clk) disable iff (reset)
      fetchValid && bankSel == 2'h1 && pc >= mmd_pkg::SecBase |=>
      fetchTarget == mmd_pkg::FetchSecondary && fetchOffset == $past(pc) - mmd_pkg::SecBase;
  endproperty
  a_dual_fetch: assert property (p_dual_fetch) else $error("dual mode fetch wrong");

  property p_upper_primary;
    @(posedge ref_clk) disable iff (reset) fetchValid && bankSel == 2'h0 &&
      pc > mmd_pkg::OverlayTop && pc <= mmd_pkg::PriTop |=>
      fetchTarget == mmd_pkg::FetchPrimary;
  endproperty
  a_upper_primary: assert property (p_upper_primary) else $error("overlay upper fetch wrong");

  property p_hidden_high;
    @(posedge ref_clk) disable iff (reset) fetchValid && bankSel[1] && pc >= mmd_pkg::SecBase
      |=> fetchTarget == mmd_pkg::FetchExternal;
  endproperty
  a_hidden_high: assert property (p_hidden_high) else $error("hidden range fetched inside");

  // Internal data space: a request is internal when it is not an external move
  sequence s_int_req;
    dataReq.valid && !dataReq.ext;
  endsequence

  property p_low_ram;
    @(posedge ref_clk) disable iff (reset) s_int_req ##0 dataReq.addr[7:0] <= mmd_pkg::LowRamTop
      |=> dataTarget == mmd_pkg::DataLowRam;
  endproperty
  a_low_ram: assert property (p_low_ram) else $error("lower RAM route wrong");

  property p_upper_ram;
    @(posedge ref_clk) disable iff (reset)
      s_int_req ##0 dataReq.addr[7:0] > mmd_pkg::LowRamTop && dataReq.indirect
      |=> dataTarget == mmd_pkg::DataUpperRam;
  endproperty
  a_upper_ram: assert property (p_upper_ram) else $error("upper RAM route wrong");

  property p_sfr;
    @(posedge ref_clk) disable iff (reset)
      s_int_req ##0 dataReq.addr[7:0] > mmd_pkg::LowRamTop && !dataReq.indirect
      |=> dataTarget == mmd_pkg::DataSfr;
  endproperty
  a_sfr: assert property (p_sfr) else $error("special register route wrong");

  // External moves through the pointer, flag clear
  sequence s_ptr_local;
    dataReq.valid && dataReq.ext && dataReq.viaPtr && !externalOnlyFlag;
  endsequence

  property p_expanded_ram_ptr;
    @(posedge ref_clk) disable iff (reset) s_ptr_local ##0 dataReq.addr <= mmd_pkg::EramTop
      |=> dataTarget == mmd_pkg::DataEram && eramAddr == $past(dataReq.addr[9:0]);
  endproperty
  a_expanded_ram_ptr: assert property (p_expanded_ram_ptr) else $error("expanded RAM pointer route wrong");

  property p_bus_ptr;
    @(posedge ref_clk) disable iff (reset) s_ptr_local ##0 dataReq.addr > mmd_pkg::EramTop
      |=> dataTarget == mmd_pkg::DataExtBus && (busOut.rdStrobe || busOut.wrStrobe);
  endproperty
  a_bus_ptr: assert property (p_bus_ptr) else $error("high pointer move missed bus");

  // Register-indirect moves reach only the first 256 expanded bytes
  property p_reg_expanded_ram;
    @(posedge ref_clk) disable iff (reset)
      dataReq.valid && dataReq.ext && !dataReq.viaPtr && !externalOnlyFlag
      |=> dataTarget == mmd_pkg::DataEram && eramAddr[9:8] == 2'h0;
  endproperty
  a_reg_expanded_ram: assert property (p_reg_expanded_ram) else $error("register move left low 256");

  property p_reg_bus;
    @(posedge ref_clk) disable iff (reset)
      dataReq.valid && dataReq.ext && !dataReq.viaPtr && externalOnlyFlag
      |=> busOut.port0En && !busOut.port2En && busOut.port0 == $past(dataReq.addr[7:0]);
  endproperty
  a_reg_bus: assert property (p_reg_bus) else $error("register move address wrong");

  // Pointer moves on the bus split the address over both ports
  property p_port_bytes;
    @(posedge ref_clk) disable iff (reset) dataReq.valid && dataReq.ext && dataReq.viaPtr &&
      externalOnlyFlag |=> busOut.port2En && busOut.port2 == $past(dataReq.addr[15:8]) &&
      busOut.port0 == $past(dataReq.addr[7:0]);
  endproperty
  a_port_bytes: assert property (p_port_bytes) else $error("pointer address bytes wrong");

  // A whole-word write shows on the selected pointer one edge later
  property p_ptr_write;
    @(posedge ref_clk) disable iff (reset) ptrWrEn && !auxWrEn && !auxInc |=>
      dataPointer == $past(ptrWrData);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

  // Select follows bit 0 of the auxiliary register written whole
  property p_sel_bit;
    @(posedge ref_clk) disable iff (reset) auxWrEn |=> pointerSelectBit == $past(auxWrData[0]);
  endproperty
  a_sel_bit: assert property (p_sel_bit) else $error("pointer select bit misplaced");
endmodule // mmd_decoder
`default_nettype wire

/* File: rtl/mmd_fetch_map.sv */
// Program fetch mapping under the bank-select field
`default_nettype none
module mmd_fetch_map (
  input wire logic [1:0] bank,
  input wire logic [15:0] pc,
  output mmd_pkg::mmd_fetch_e target,
  output logic [15:0] offset
);
  // Pure decode; the caller registers the result
  always_comb begin
    target = mmd_pkg::FetchExternal;
    offset = pc;
    if (bank[mmd_pkg::BankHiPos]) begin
      if (pc <= mmd_pkg::PriTop) target = mmd_pkg::FetchPrimary;
    end else if (bank[mmd_pkg::BankLoPos]) begin
      if (pc <= mmd_pkg::PriTop) begin
        target = mmd_pkg::FetchPrimary;
      end else if (pc >= mmd_pkg::SecBase) begin
        target = mmd_pkg::FetchSecondary;
        offset = pc - mmd_pkg::SecBase;
      end
    end else begin
      if (pc <= mmd_pkg::OverlayTop) target = mmd_pkg::FetchSecondary;
      else if (pc <= mmd_pkg::PriTop) target = mmd_pkg::FetchPrimary;
    end
  end
endmodule // mmd_fetch_map
`default_nettype wire

/* File: rtl/mmd_pkg.sv */
// Package of constants and carrier types for the memory map decoder
`default_nettype none
package mmd_pkg;
  localparam logic [15:0] SecBase = 16'he000;
  localparam logic [15:0] PriTop = 16'h7fff;
  localparam logic [15:0] OverlayTop = 16'h1fff;
  localparam logic [15:0] EramTop = 16'h02ff;
  localparam logic [7:0] LowRamTop = 8'h7f;
  localparam int SelBitPos = 0;
  localparam int BankHiPos = 1;
  localparam int BankLoPos = 0;
  localparam logic [1:0] BankPorReset = 2'h0;

  typedef enum logic [1:0] {FetchNone, FetchPrimary, FetchSecondary, FetchExternal} mmd_fetch_e;
  typedef enum logic [2:0] {
    DataNone, DataLowRam, DataUpperRam, DataSfr, DataEram, DataExtBus
  } mmd_data_e;
  typedef enum logic [2:0] {RstNone, RstPor, RstWdt, RstBod, RstSoft} mmd_rst_e;

  // Data access request from the core
  typedef struct packed {
    logic valid;
    logic ext;       // External move instruction
    logic viaPtr;    // Pointer based, else register indirect
    logic indirect;  // Internal indirect (or stack)
    logic write;
    logic [15:0] addr;
  } mmd_dreq_s;

  // External bus drive for one access
  typedef struct packed {
    logic rdStrobe;
    logic wrStrobe;
    logic port2En;
    logic [7:0] port2;
    logic port0En;
    logic [7:0] port0;
  } mmd_bus_s;
endpackage
`default_nettype wire

/* File: verification/mmd_ext_bus_model.sv */
// Far-side bus model: latches the address shown during each strobed external cycle
`default_nettype none
module mmd_ext_bus_model (
  input wire logic ref_clk,
  input wire mmd_pkg::mmd_bus_s busOut,
  output logic [15:0] lastAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port 2 only counts while driven; otherwise the upper bits are paging pins, read as zero
  always_ff @(posedge ref_clk) begin
    if (busOut.rdStrobe || busOut.wrStrobe) begin
      lastAddr <= {busOut.port2En ? busOut.port2 : 8'h00, busOut.port0};
    end
  end
endmodule // mmd_ext_bus_model
`default_nettype wire

/* File: verification/test_mmd_decoder.sv */
// Self-checking bench of the memory map decoder
`default_nettype none
module test_mmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1, cfgLow = 1'b1, cfgHigh = 1'b1, extOnly = 1'b0;
  logic bankLowWrEn = 1'b0, bankLowWrData = 1'b0, fetchValid = 1'b0, isExt;
  logic auxWrEn = 1'b0, auxInc = 1'b0, ptrWrEn = 1'b0, ptrInc = 1'b0, pointerSelectBit;
  logic [7:0] auxWrData = 8'h00;
  logic [15:0] pc = 16'h0000, ptrWrData = 16'h0000, fetchOffset, dataPointer, lastAddr;
  logic [1:0] bankSel, expB = 2'h0, expS;
  logic [9:0] eramAddr;
  mmd_pkg::mmd_rst_e resetCause = mmd_pkg::RstPor;
  mmd_pkg::mmd_dreq_s dataReq = '0;
  mmd_pkg::mmd_fetch_e fetchTarget, f;
  mmd_pkg::mmd_data_e dataTarget, t;
  mmd_pkg::mmd_bus_s busOut;
  int failures = 0, num_checks = 0, i, j;
  integer seed = 32'h7bd8;
  logic [15:0] corner [7] = '{16'h1fff, 16'h2000, 16'h7fff, 16'h8000,
    16'hdfff, 16'he000, 16'hffff};

  mmd_decoder i_dut (.ref_clk(ref_clk), .reset(reset), .resetCause(resetCause),
    .startupCfgLow(cfgLow), .startupCfgHigh(cfgHigh), .bankLowWrEn(bankLowWrEn),
    .bankLowWrData(bankLowWrData), .fetchValid(fetchValid), .pc(pc), .dataReq(dataReq),
    .auxWrEn(auxWrEn), .auxWrData(auxWrData), .auxInc(auxInc), .ptrWrEn(ptrWrEn),
    .ptrWrData(ptrWrData), .ptrInc(ptrInc), .externalOnlyFlag(extOnly), .bankSel(bankSel),
    .fetchTarget(fetchTarget), .fetchOffset(fetchOffset), .dataTarget(dataTarget),
    .eramAddr(eramAddr), .busOut(busOut), .pointerSelectBit(pointerSelectBit),
    .dataPointer(dataPointer));
  mmd_ext_bus_model i_bus (.ref_clk(ref_clk), .busOut(busOut), .lastAddr(lastAddr));

  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [1:0] expBank(mmd_pkg::mmd_rst_e c, logic h, logic l, logic [1:0] p);
    case (c)
      mmd_pkg::RstPor: return {~h, ~l};
      mmd_pkg::RstWdt, mmd_pkg::RstBod: return {h ? p[1] : 1'b1, ~l};
      mmd_pkg::RstSoft: return {1'b1, ~l};
      default: return 2'h0;
    endcase
  endfunction

  function automatic mmd_pkg::mmd_fetch_e expFetch(logic [1:0] b, logic [15:0] a);
    if (b == 2'h1 && a >= mmd_pkg::SecBase) return mmd_pkg::FetchSecondary;
    if (b == 2'h0 && a <= mmd_pkg::OverlayTop) return mmd_pkg::FetchSecondary;
    if (a <= mmd_pkg::PriTop) return mmd_pkg::FetchPrimary;
    return mmd_pkg::FetchExternal;
  endfunction

  function automatic mmd_pkg::mmd_data_e expData(mmd_pkg::mmd_dreq_s r, logic x);
    if (!r.ext) begin
      if (r.addr[7:0] <= mmd_pkg::LowRamTop) return mmd_pkg::DataLowRam;
      return r.indirect ? mmd_pkg::DataUpperRam : mmd_pkg::DataSfr;
    end
    if (x || (r.viaPtr && r.addr > mmd_pkg::EramTop)) return mmd_pkg::DataExtBus;
    return mmd_pkg::DataEram;
  endfunction

  // Reset of a given kind; the expected bank is tracked here, not read back
  task automatic do_reset(input mmd_pkg::mmd_rst_e c, input logic h, input logic l);
    expB = expBank(c, h, l, expB);
    reset = 1'b1;
    resetCause = c;
    cfgHigh = h;
    cfgLow = l;
    @(negedge ref_clk);
    reset = 1'b0;
    check(bankSel, expB);
    check(dataPointer, 16'h0000);
    // One idle cycle so reset never drops and rises in the same time step
    @(negedge ref_clk);
  endtask

  // Watchdog cuts a hang well past the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (16) @(negedge ref_clk);
    do_reset(mmd_pkg::RstPor, 1'b1, 1'b1);
    // Random reset kinds and start-up bits, so watchdog sees both kept upper-bit states
    for (i = 0; i < 40; i++) begin
      do_reset(mmd_pkg::mmd_rst_e'(3'($unsigned($random(seed)) % 5)), 1'($random(seed)),
        1'($random(seed)));
    end
    // Back-to-back fetches in each bank mode, corner addresses first
    for (i = 0; i < 3; i++) begin
      do_reset(mmd_pkg::RstPor, i != 2, i == 0);
      fetchValid = 1'b1;
      for (j = 0; j < 30; j++) begin
        pc = j < 7 ? corner[j] : 16'($random(seed));
        @(negedge ref_clk);
        f = expFetch(expB, pc);
        check(fetchTarget, f);
        if (f == mmd_pkg::FetchSecondary && expB == 2'h1)
          check(fetchOffset, pc - mmd_pkg::SecBase);
      end
      fetchValid = 1'b0;
    end
    // Software bank write away from the low 8K, then a fetch right after
    do_reset(mmd_pkg::RstPor, 1'b1, 1'b1);
    pc = 16'he000;
    bankLowWrEn = 1'b1;
    bankLowWrData = 1'b1;
    @(negedge ref_clk);
    bankLowWrEn = 1'b0;
    fetchValid = 1'b1;
    expB = 2'h1;
    check(bankSel, 2'h1);
    @(negedge ref_clk);
    fetchValid = 1'b0;
    check(fetchTarget, mmd_pkg::FetchSecondary);
    do_reset(mmd_pkg::RstWdt, 1'b1, 1'b1);
    // Random data requests, pointer addresses bunched at the expanded RAM top
    for (j = 0; j < 300; j++) begin
      dataReq = 21'($random(seed));
      dataReq.valid = 1'b1;
      if (!j[0]) dataReq.addr = 16'h02fe + 16'(j[2:1]);
      if (!dataReq.ext) dataReq.addr[15:8] = 8'h00;
      extOnly = 1'($random(seed));
      @(negedge ref_clk);
      t = expData(dataReq, extOnly);
      isExt = t == mmd_pkg::DataExtBus;
      check(dataTarget, t);
      expS = isExt ? {~dataReq.write, dataReq.write} : 2'h0;
      check({busOut.rdStrobe, busOut.wrStrobe}, expS);
      check(busOut.port2En, isExt && dataReq.viaPtr);
      if (isExt) check(busOut.port0, dataReq.addr[7:0]);
      if (t == mmd_pkg::DataEram)
        check(eramAddr, dataReq.viaPtr ? dataReq.addr[9:0] : {2'h0, dataReq.addr[7:0]});
      if (isExt) begin
        @(negedge ref_clk);
        check(lastAddr, dataReq.viaPtr ? dataReq.addr : {8'h00, dataReq.addr[7:0]});
      end
    end
    dataReq.valid = 1'b0;
    // Two pointers: write first, increment select, write second, then priorities
    ptrWrEn = 1'b1;
    ptrWrData = 16'h1234;
    @(negedge ref_clk);
    ptrWrEn = 1'b0;
    auxInc = 1'b1;
    check(dataPointer, 16'h1234);
    @(negedge ref_clk);
    auxInc = 1'b0;
    ptrWrEn = 1'b1;
    ptrWrData = 16'hffff;
    check(pointerSelectBit, 1'b1);
    @(negedge ref_clk);
    ptrWrEn = 1'b0;
    ptrInc = 1'b1;
    check(dataPointer, 16'hffff);
    @(negedge ref_clk);
    ptrInc = 1'b0;
    auxWrEn = 1'b1;
    auxWrData = 8'hfe;
    auxInc = 1'b1;
    check(dataPointer, 16'h0000);
    @(negedge ref_clk);
    auxWrEn = 1'b0;
    check(pointerSelectBit, 1'b0);
    check(dataPointer, 16'h1234);
    @(negedge ref_clk);
    auxInc = 1'b0;
    check(dataPointer, 16'h0000);
    print_verdict();
  end
endmodule // test_mmd_decoder
`default_nettype wire
